/* File: sft_flash_target.sv */
// sft_flash_target: serial flash target core with its array, program/erase engine and AHB-Lite peek port.
// assumes an SPI master on the pins and a single-word AHB-Lite master on the register port.
// Summary of operation
// [R1] serial output changes only after clock falls
// [R2] input bits captured on clock rising edges
// [R3] deselected means output floated
// [R4] deselected and idle means standby, not power-down
// [R5] no instruction before first select falling edge
// [R6] pause floats output, ignores clock and input
// [R7] master holds select low while pausing
// [R8] protect pin can lock block-protect bits
// [R9] only modes 0 and 3, same edges
// [R10] enable, then opcode, address, data program
// [R11] up to 256 bytes within one page
// [R12] master should program runs in one frame
// [R13] program only clears bits, erase first
// [R14] sector and bulk erase run own cycles
// [R15] erase needs write enable first
// [R16] four sectors, 256 pages, 256 bytes each
// [R17] everything shifted most significant bit first
// [R18] pause edges act only while clock low
// [R19] enable latch cleared by reset and writes
// [R20] writes need whole bytes of clock pulses
// [R21] program and erase ignored without latch
// [R22] busy held for whole internal cycle
`timescale 1ns/1ps
module sft_flash_target (
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	input wire logic spi_cs_n_i,
	input wire logic spi_sck_i,
	input wire logic spi_mosi_i,
	input wire logic spi_hold_n_i,
	input wire logic spi_wp_n_i,
	output logic spi_miso_o,
	output logic spi_miso_oe_o,
	output logic busy_o,
	output logic standby_o,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic hreadyout_o,
	output logic hresp_o,
	output logic [31:0] hrdata_o
);
	sft_pin_if pin ();

	sft_pin_sync u_pin_sync (
		.clk_sys_i(clk_sys_i),
		.rstn_i(rstn_i),
		.ce_i(ce_i),
		.cs_n_i(spi_cs_n_i),
		.sck_i(spi_sck_i),
		.mosi_i(spi_mosi_i),
		.hold_n_i(spi_hold_n_i),
		.wp_n_i(spi_wp_n_i),
		.pin(pin)
	);

	// 4 sectors x 256 pages x 256 bytes; contents are undefined until erased
	logic [7:0] mem [0:sft_pkg::MEM_BYTES-1]; // see [R16]
	logic [7:0] pbuf [0:sft_pkg::PAGE_BYTES-1];
	logic [sft_pkg::PAGE_BYTES-1:0] pmask_reg;

	logic armed_reg;
	logic [2:0] bit_cnt_reg;
	logic [3:0] byte_cnt_reg;
	logic [6:0] shift_reg;
	logic [7:0] opcode_reg;
	logic [7:0] sr_stage_reg;
	logic [sft_pkg::ADDR_W-1:0] addr_reg;
	logic [7:0] wr_ptr_reg;
	logic [7:0] tx_reg;
	logic tx_live_reg;
	logic miso_reg;
	logic wel_reg;
	logic [1:0] bp_reg;
	logic srwd_reg;
	logic inhibit_reg;
	logic [sft_pkg::ADDR_W-1:0] peek_addr_reg;
	sft_pkg::sft_op_state_t op_state_reg;
	logic [sft_pkg::ADDR_W-1:0] op_cnt_reg;
	logic [sft_pkg::ADDR_W-1:0] op_base_reg;
	logic [sft_pkg::ADDR_W-1:0] op_last_reg;
	logic [7:0] op_stage_reg;
	logic [sft_pkg::ADDR_W-1:0] bus_addr_reg;
	logic bus_wr_reg;
	logic [31:0] hrdata_reg;

	logic busy;
	logic rx;
	logic byte_done;
	logic [7:0] byte_val;
	logic [7:0] status_byte;
	logic [sft_pkg::ADDR_W-1:0] addr_full;
	logic commit;
	logic cmd_ok;
	logic wel_cmd;
	logic start_prog;
	logic start_sector;
	logic start_bulk;
	logic start_status;
	logic [sft_pkg::ADDR_W-1:0] prog_addr;
	logic bus_take;

	function automatic logic is_protected(input logic [1:0] sector, input logic [1:0] bp);
		logic p;
		p = 1'b0;
		unique case (bp)
			2'h0: p = 1'b0;
			2'h1: p = (sector == 2'h3);
			2'h2: p = sector[1];
			2'h3: p = 1'b1;
		endcase
		return p;
	endfunction

	assign busy = (op_state_reg != sft_pkg::OP_IDLE);
	assign busy_o = busy; // see [R22]
	assign standby_o = !pin.selected && !busy; // see [R4]

	// nothing is shifted before the first select fall, nor during pause
	assign rx = pin.sck_rise && pin.selected && !pin.hold_active && armed_reg; // see [R2] see [R6]
	assign byte_done = rx && (bit_cnt_reg == 3'h7);
	assign byte_val = {shift_reg, pin.mosi}; // see [R17]
	assign addr_full = {addr_reg[9:0], byte_val};

	always_comb begin
		status_byte = 8'h00;
		status_byte[sft_pkg::SB_BUSY] = busy;
		status_byte[sft_pkg::SB_WEL] = wel_reg;
		status_byte[sft_pkg::SB_BP_LO] = bp_reg[0];
		status_byte[sft_pkg::SB_BP_HI] = bp_reg[1];
		status_byte[sft_pkg::SB_SRWD] = srwd_reg;
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			armed_reg <= 1'b0;
		end else if (ce_i && pin.cs_fall) begin
			armed_reg <= 1'b1; // see [R5]
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			bit_cnt_reg <= 3'h0;
			byte_cnt_reg <= 4'h0;
			shift_reg <= 7'h00;
		end else if (ce_i) begin
			if (pin.cs_fall) begin
				bit_cnt_reg <= 3'h0;
				byte_cnt_reg <= 4'h0;
			end else if (rx) begin
				bit_cnt_reg <= bit_cnt_reg + 3'h1;
				shift_reg <= byte_val[6:0];
				if (byte_done && byte_cnt_reg != sft_pkg::LEN_SATURATE) begin
					byte_cnt_reg <= byte_cnt_reg + 4'h1;
				end
			end
		end
	end

	// opcode, address and staged status byte; a data read walks the address forward
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			opcode_reg <= 8'h00;
			addr_reg <= '0;
			sr_stage_reg <= 8'h00;
			wr_ptr_reg <= 8'h00;
		end else if (ce_i && byte_done) begin
			if (byte_cnt_reg == 4'h0) begin
				opcode_reg <= byte_val;
			end else if (byte_cnt_reg <= 4'h3) begin
				addr_reg <= addr_full;
				if (byte_cnt_reg == 4'h1) begin
					sr_stage_reg <= byte_val;
				end
				if (byte_cnt_reg == 4'h3) begin
					wr_ptr_reg <= byte_val;
					if (opcode_reg == sft_pkg::OPC_DATA_READ) begin
						addr_reg <= addr_full + 18'h00001;
					end
				end
			end else if (opcode_reg == sft_pkg::OPC_DATA_READ) begin
				addr_reg <= addr_reg + 18'h00001;
			end else begin
				wr_ptr_reg <= wr_ptr_reg + 8'h01; // see [R11]
			end
		end
	end

	// data bytes land in the page buffer, wrapping inside the page; frozen while an internal cycle runs
	always_ff @(posedge clk_sys_i) begin
		if (ce_i && byte_done && !busy && byte_cnt_reg >= 4'h4 && opcode_reg == sft_pkg::OPC_PAGE_PROGRAM) begin
			pbuf[wr_ptr_reg] <= byte_val; // see [R11]
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pmask_reg <= '0;
		end else if (ce_i && byte_done && !busy) begin
			if (byte_cnt_reg == 4'h0) begin
				pmask_reg <= '0;
			end else if (byte_cnt_reg >= 4'h4 && opcode_reg == sft_pkg::OPC_PAGE_PROGRAM) begin
				pmask_reg[wr_ptr_reg] <= 1'b1;
			end
		end
	end

	// transmit: a byte is loaded on the rising edge that ends a byte, then shifted on each fall
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tx_reg <= 8'h00;
			tx_live_reg <= 1'b0;
			miso_reg <= 1'b0;
		end else if (ce_i) begin
			if (pin.cs_fall) begin
				tx_live_reg <= 1'b0;
			end else if (byte_done) begin
				if (byte_cnt_reg == 4'h0 && byte_val == sft_pkg::OPC_STATUS_READ) begin
					tx_reg <= status_byte;
					tx_live_reg <= 1'b1;
				end else if (byte_cnt_reg != 4'h0 && opcode_reg == sft_pkg::OPC_STATUS_READ) begin
					tx_reg <= status_byte;
				end else if (byte_cnt_reg == 4'h3 && opcode_reg == sft_pkg::OPC_DATA_READ && !busy) begin
					tx_reg <= mem[addr_full];
					tx_live_reg <= 1'b1;
				end else if (tx_live_reg && opcode_reg == sft_pkg::OPC_DATA_READ) begin
					tx_reg <= mem[addr_reg];
				end
			end else if (pin.sck_fall && pin.selected && !pin.hold_active && tx_live_reg) begin
				miso_reg <= tx_reg[7]; // see [R1] see [R17]
				tx_reg <= {tx_reg[6:0], 1'b0};
			end
		end
	end

	assign spi_miso_o = miso_reg;
	assign spi_miso_oe_o = pin.selected && !pin.hold_active && tx_live_reg; // see [R3] see [R6]

	// a frame counts on select rising; a select rise inside pause discards the frame
	assign commit = ce_i && pin.cs_rise && armed_reg && !pin.hold_active && bit_cnt_reg == 3'h0; // see [R20]
	assign cmd_ok = commit && !busy && !inhibit_reg;
	assign wel_cmd = cmd_ok && wel_reg; // see [R21] see [R15]
	assign start_prog = wel_cmd && opcode_reg == sft_pkg::OPC_PAGE_PROGRAM
		&& byte_cnt_reg >= sft_pkg::LEN_PROGRAM_MIN; // see [R10]
	assign start_sector = wel_cmd && opcode_reg == sft_pkg::OPC_SECTOR_ERASE
		&& byte_cnt_reg == sft_pkg::LEN_SECTOR_ERASE && !is_protected(addr_reg[17:16], bp_reg);
	assign start_bulk = wel_cmd && opcode_reg == sft_pkg::OPC_BULK_ERASE
		&& byte_cnt_reg == sft_pkg::LEN_SHORT && bp_reg == 2'h0;
	// with the lock bit set, a low protect pin refuses status writes
	assign start_status = wel_cmd && opcode_reg == sft_pkg::OPC_STATUS_WRITE
		&& byte_cnt_reg >= sft_pkg::LEN_STATUS_WRITE && !(srwd_reg && !pin.wp_n); // see [R8]

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			wel_reg <= 1'b0; // see [R19]
		end else if (cmd_ok) begin
			if (opcode_reg == sft_pkg::OPC_WRITE_ENABLE && byte_cnt_reg == sft_pkg::LEN_SHORT) begin
				wel_reg <= 1'b1;
			end else if (opcode_reg == sft_pkg::OPC_WRITE_DISABLE && byte_cnt_reg == sft_pkg::LEN_SHORT) begin
				wel_reg <= 1'b0; // see [R19]
			end else if (start_prog || start_sector || start_bulk || start_status) begin
				wel_reg <= 1'b0; // see [R19]
			end
		end
	end

	// internal cycle engine: program walks the page, erase walks its range, status write waits
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			op_state_reg <= sft_pkg::OP_IDLE;
			op_cnt_reg <= '0;
			op_base_reg <= '0;
			op_last_reg <= '0;
			op_stage_reg <= 8'h00;
		end else if (ce_i) begin
			unique case (op_state_reg)
				sft_pkg::OP_IDLE: begin
					op_cnt_reg <= '0;
					op_stage_reg <= sr_stage_reg;
					if (start_prog) begin
						op_state_reg <= sft_pkg::OP_PROGRAM;
						op_base_reg <= {addr_reg[17:8], 8'h00};
						op_last_reg <= 18'(sft_pkg::PAGE_BYTES - 1);
					end else if (start_sector) begin
						op_state_reg <= sft_pkg::OP_ERASE; // see [R14]
						op_base_reg <= {addr_reg[17:16], 16'h0000};
						op_last_reg <= 18'(sft_pkg::SECTOR_BYTES - 1);
					end else if (start_bulk) begin
						op_state_reg <= sft_pkg::OP_ERASE; // see [R14]
						op_base_reg <= '0;
						op_last_reg <= 18'(sft_pkg::MEM_BYTES - 1);
					end else if (start_status) begin
						op_state_reg <= sft_pkg::OP_STATUS;
						op_last_reg <= 18'(sft_pkg::STATUS_WRITE_CYCLES - 1);
					end
				end
				sft_pkg::OP_PROGRAM, sft_pkg::OP_ERASE, sft_pkg::OP_STATUS: begin
					op_cnt_reg <= op_cnt_reg + 18'h00001;
					if (op_cnt_reg == op_last_reg) begin
						op_state_reg <= sft_pkg::OP_IDLE; // see [R22]
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			bp_reg <= sft_pkg::BP_RST;
			srwd_reg <= sft_pkg::SRWD_RST;
		end else if (ce_i && op_state_reg == sft_pkg::OP_STATUS && op_cnt_reg == op_last_reg) begin
			bp_reg <= {op_stage_reg[sft_pkg::SB_BP_HI], op_stage_reg[sft_pkg::SB_BP_LO]};
			srwd_reg <= op_stage_reg[sft_pkg::SB_SRWD];
		end
	end

	assign prog_addr = op_base_reg | op_cnt_reg;

	// programming ANDs into the cell, so it can only clear bits
	always_ff @(posedge clk_sys_i) begin
		if (ce_i && op_state_reg == sft_pkg::OP_PROGRAM && pmask_reg[op_cnt_reg[7:0]]
			&& !is_protected(prog_addr[17:16], bp_reg)) begin
			mem[prog_addr] <= mem[prog_addr] & pbuf[op_cnt_reg[7:0]]; // see [R13]
		end else if (ce_i && op_state_reg == sft_pkg::OP_ERASE) begin
			mem[prog_addr] <= 8'hFF; // see [R14]
		end
	end

	// AHB-Lite slave: zero wait states, stalls only while the clock enable is low
	assign bus_take = ce_i && hsel_i && hready_i && htrans_i == sft_pkg::HTRANS_NONSEQ;
	assign hreadyout_o = ce_i;
	assign hresp_o = 1'b0;
	assign hrdata_o = hrdata_reg;

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			bus_wr_reg <= 1'b0;
			bus_addr_reg <= '0;
		end else if (ce_i) begin
			bus_wr_reg <= bus_take && hwrite_i;
			if (bus_take) begin
				bus_addr_reg <= haddr_i[17:0];
			end
		end
	end

	// read data is captured at the address phase so it stands through the data phase
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			hrdata_reg <= 32'h00000000;
		end else if (bus_take && !hwrite_i) begin
			hrdata_reg <= 32'h00000000;
			if (haddr_i[31:8] == 24'h000000) begin
				unique case (haddr_i[7:0])
					sft_pkg::REG_STATUS: begin
						hrdata_reg[7:0] <= status_byte;
						hrdata_reg[sft_pkg::ST_ARMED] <= armed_reg;
						hrdata_reg[sft_pkg::ST_SELECTED] <= pin.selected;
						hrdata_reg[sft_pkg::ST_HOLD] <= pin.hold_active;
						hrdata_reg[sft_pkg::ST_STANDBY] <= standby_o;
					end
					sft_pkg::REG_CTRL: hrdata_reg[sft_pkg::CTRL_INHIBIT] <= inhibit_reg;
					sft_pkg::REG_PEEK_ADDR: hrdata_reg[17:0] <= peek_addr_reg;
					sft_pkg::REG_PEEK_DATA: hrdata_reg[7:0] <= mem[peek_addr_reg];
					default: hrdata_reg <= 32'h00000000;
				endcase
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			inhibit_reg <= sft_pkg::CTRL_INHIBIT_RST;
			peek_addr_reg <= '0;
		end else if (ce_i && bus_wr_reg) begin
			if (bus_addr_reg == 18'(sft_pkg::REG_CTRL)) begin
				inhibit_reg <= hwdata_i[sft_pkg::CTRL_INHIBIT];
			end else if (bus_addr_reg == 18'(sft_pkg::REG_PEEK_ADDR)) begin
				peek_addr_reg <= hwdata_i[17:0];
			end
		end
	end
endmodule // sft_flash_target

/* File: sft_flash_target_asserts.sv */
// sft_flash_target_asserts: pin-level checks on the serial flash target.
// assumes it is bound into sft_flash_target and sees only its ports.
`timescale 1ns/1ps
module sft_flash_target_chk (
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire logic spi_cs_n_i,
	input wire logic spi_sck_i,
	input wire logic spi_hold_n_i,
	input wire logic spi_miso_o,
	input wire logic spi_miso_oe_o,
	input wire logic busy_o,
	input wire logic standby_o
);
	logic [19:0] busy_len_reg;
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rstn_i);
	// length of the running internal cycle, judged when busy drops
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			busy_len_reg <= 20'h00000;
		end else begin
			busy_len_reg <= busy_o ? busy_len_reg + 20'h00001 : 20'h00000;
		end
	end
	sequence s_desel;
		spi_cs_n_i [*5];
	endsequence
	sequence s_sel;
		!spi_cs_n_i [*4];
	endsequence
	chk_oe_desel: assert property (s_desel |-> !spi_miso_oe_o)
		else $error("output driven while deselected");
	chk_oe_pause: assert property ((!spi_hold_n_i && !spi_sck_i) [*6] |-> !spi_miso_oe_o)
		else $error("output driven while paused");
	chk_out_edge: assert property ($changed(spi_miso_o) && spi_miso_oe_o
		|-> !$past(spi_sck_i, 2) && $past(spi_sck_i, 8)) else $error("output changed away from a clock fall");
	chk_stby_busy: assert property (busy_o |-> !standby_o)
		else $error("standby during internal cycle");
	chk_stby_sel: assert property (s_sel |-> !standby_o)
		else $error("standby while selected");
	chk_stby_idle: assert property (s_desel ##0 !busy_o |-> standby_o)
		else $error("no standby when idle");
	// the status write is the shortest internal cycle
	chk_busy_len: assert property ($fell(busy_o) |-> busy_len_reg >= 20'(sft_pkg::STATUS_WRITE_CYCLES))
		else $error("internal cycle ended early");
	chk_busy_start: assert property ($rose(busy_o) |-> spi_cs_n_i && $past(spi_cs_n_i, 2))
		else $error("internal cycle started while selected");
endmodule // sft_flash_target_chk

bind sft_flash_target sft_flash_target_chk u_chk (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
	.spi_cs_n_i(spi_cs_n_i), .spi_sck_i(spi_sck_i), .spi_hold_n_i(spi_hold_n_i), .spi_miso_o(spi_miso_o),
	.spi_miso_oe_o(spi_miso_oe_o), .busy_o(busy_o), .standby_o(standby_o));

/* File: sft_flash_target_tb.sv */
// sft_flash_target_tb: self-checking bench for the serial flash target.
// assumes sft_spi_master on the link pins; the bench is the AHB-Lite master.
`timescale 1ns/1ps
module sft_flash_target_tb;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic wp_n = 1'b1;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h00000000;
	logic [31:0] hwdata = 32'h00000000;
	logic cs_n, sck, mosi, hold_n, miso, miso_oe, busy, standby, hready, hresp, miso_line;
	logic [31:0] hrdata, rd;
	int bad_count = 0;
	int tests_run = 0;
	always #2 clk = ~clk;
	// a floated line reads as the inverse of the last bit, so a sample taken while undriven fails
	assign miso_line = miso_oe ? miso : ~miso;
	sft_spi_master u_spi (.cs_n_o(cs_n), .sck_o(sck), .mosi_o(mosi), .hold_n_o(hold_n), .miso_i(miso_line));
	sft_flash_target u_dut (.clk_sys_i(clk), .rstn_i(rstn), .ce_i(1'b1), .spi_cs_n_i(cs_n), .spi_sck_i(sck),
		.spi_mosi_i(mosi), .spi_hold_n_i(hold_n), .spi_wp_n_i(wp_n), .spi_miso_o(miso), .spi_miso_oe_o(miso_oe),
		.busy_o(busy), .standby_o(standby), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
		.hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata));
	task automatic results();
		$display("checks %0d errors %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			$display("ERROR %s expected %h seen %h", nm, exp, got);
			bad_count++;
		end
	endtask
	task automatic edge_rdy();
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (hready !== 1'b1 && n < 100);
		if (n >= 100) begin
			cmp("bus wait", 32'h1, 32'h0);
			results();
		end
	endtask
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rdv);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= sft_pkg::HTRANS_NONSEQ;
		haddr <= {24'h000000, a};
		hwrite <= wr;
		edge_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		edge_rdy();
		rdv = hrdata;
	endtask
	task automatic send(input logic [7:0] q[$], input int cut = 0);
		u_spi.tx_q = q;
		u_spi.frame(8 * q.size() - cut);
	endtask
	task automatic write_enable_cmd();
		send('{sft_pkg::OPC_WRITE_ENABLE});
	endtask
	task automatic stat(input string nm, input logic [7:0] mask, input logic [7:0] exp);
		ahb(1'b0, sft_pkg::REG_STATUS, 32'h0, rd);
		cmp(nm, {24'h0, exp}, {24'h0, rd[7:0] & mask});
	endtask
	task automatic peek(input logic [17:0] a, input logic [7:0] exp);
		ahb(1'b1, sft_pkg::REG_PEEK_ADDR, {14'h0, a}, rd);
		ahb(1'b0, sft_pkg::REG_PEEK_DATA, 32'h0, rd);
		cmp("array byte", {24'h0, exp}, rd);
	endtask
	// erase of a whole sector is the longest wait in the run
	task automatic wait_idle();
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 70000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 70000) begin
			cmp("busy wait", 32'h0, 32'h1);
			results();
		end
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		write_enable_cmd();
		stat("latch before select fall", 8'h02, 8'h00);
		write_enable_cmd();
		stat("latch set", 8'h03, 8'h02);
		cmp("standby", 32'h1, {31'h0, standby});
		send('{sft_pkg::OPC_WRITE_DISABLE});
		stat("latch after disable", 8'h02, 8'h00);
		send('{sft_pkg::OPC_SECTOR_ERASE, 8'h00, 8'h01, 8'h00});
		cmp("erase without latch", 32'h0, {31'h0, busy});
		write_enable_cmd();
		send('{sft_pkg::OPC_SECTOR_ERASE, 8'h00, 8'h01, 8'h00}, 1);
		stat("short frame", 8'h03, 8'h02);
		send('{sft_pkg::OPC_SECTOR_ERASE, 8'h00, 8'h01, 8'h00});
		stat("erase running", 8'h03, 8'h01);
		// status read is the one instruction answered while busy
		send('{sft_pkg::OPC_STATUS_READ, 8'h00, 8'h00});
		cmp("status byte 0", 32'h01, {24'h0, u_spi.rx_q[1]});
		cmp("status byte 1", 32'h01, {24'h0, u_spi.rx_q[2]});
		wait_idle();
		peek(18'h00100, 8'hFF);
		peek(18'h0FFFF, 8'hFF);
		ahb(1'b1, sft_pkg::REG_PEEK_ADDR, 32'hFFFFFFFF, rd);
		ahb(1'b0, sft_pkg::REG_PEEK_ADDR, 32'h0, rd);
		cmp("address width", 32'h0003FFFF, rd);
		write_enable_cmd();
		send('{sft_pkg::OPC_PAGE_PROGRAM, 8'h00, 8'h00, 8'hFE, 8'hA5, 8'h3C, 8'h0F});
		cmp("busy after program", 32'h1, {31'h0, busy});
		wait_idle();
		peek(18'h000FE, 8'hA5);
		peek(18'h000FF, 8'h3C);
		peek(18'h00000, 8'h0F);
		write_enable_cmd();
		send('{sft_pkg::OPC_PAGE_PROGRAM, 8'h00, 8'h00, 8'hFE, 8'hF0});
		wait_idle();
		peek(18'h000FE, 8'hA0);
		u_spi.cpol = 1'b1;
		// pause inside the first data byte, so the output is live when it must float
		u_spi.pause_bit = 36;
		send('{sft_pkg::OPC_DATA_READ, 8'h00, 8'h00, 8'hFE, 8'h00, 8'h00});
		cmp("read byte 0", 32'hA0, {24'h0, u_spi.rx_q[4]});
		cmp("read byte 1", 32'h3C, {24'h0, u_spi.rx_q[5]});
		u_spi.cpol = 1'b0;
		u_spi.pause_bit = -1;
		write_enable_cmd();
		send('{sft_pkg::OPC_STATUS_WRITE, 8'h8C});
		wait_idle();
		stat("protect bits set", 8'hFF, 8'h8C);
		@(posedge clk);
		wp_n <= 1'b0;
		write_enable_cmd();
		send('{sft_pkg::OPC_STATUS_WRITE, 8'h00});
		wait_idle();
		stat("protect bits locked", 8'h8C, 8'h8C);
		write_enable_cmd();
		send('{sft_pkg::OPC_BULK_ERASE});
		cmp("bulk erase protected", 32'h0, {31'h0, busy});
		send('{sft_pkg::OPC_WRITE_DISABLE});
		ahb(1'b1, sft_pkg::REG_CTRL, 32'h1, rd);
		ahb(1'b0, sft_pkg::REG_CTRL, 32'h0, rd);
		cmp("inhibit readback", 32'h1, rd);
		write_enable_cmd();
		stat("latch inhibited", 8'h02, 8'h00);
		ahb(1'b0, 8'h10, 32'h0, rd);
		cmp("unmapped read", 32'h0, rd);
		ahb(1'b0, sft_pkg::REG_STATUS, 32'h0, rd);
		cmp("armed", 32'h1, {31'h0, rd[sft_pkg::ST_ARMED]});
		cmp("bus response", 32'h0, {31'h0, hresp});
		results();
	end
endmodule // sft_flash_target_tb

/* File: sft_pin_if.sv */
// sft_pin_if: synchronised link events passed from the pin front end to the core.
// assumes both ends run on clk_sys_i.
`timescale 1ns/1ps
interface sft_pin_if;
	logic sck_rise;
	logic sck_fall;
	logic cs_rise;
	logic cs_fall;
	logic selected;
	logic mosi;
	logic wp_n;
	logic hold_active;

	modport src (output sck_rise, sck_fall, cs_rise, cs_fall, selected, mosi, wp_n, hold_active);
	modport dst (input sck_rise, sck_fall, cs_rise, cs_fall, selected, mosi, wp_n, hold_active);
endinterface

/* File: sft_pin_sync.sv */
// sft_pin_sync: two-stage synchronisers for the link pins, edge finding and pause tracking.
// assumes the link clock is far slower than clk_sys_i (at least four system cycles per level).
`timescale 1ns/1ps
module sft_pin_sync (
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	input wire logic cs_n_i,
	input wire logic sck_i,
	input wire logic mosi_i,
	input wire logic hold_n_i,
	input wire logic wp_n_i,
	sft_pin_if.src pin
);
	// bit order: {wp_n, hold_n, mosi, sck, cs_n}
	logic [4:0] meta_reg;
	logic [4:0] sync_reg;
	logic sck_prev_reg;
	logic cs_prev_reg;
	logic hold_reg;

	// select resets as "low" so a pin already low at reset never looks like a falling edge
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			meta_reg <= 5'h00;
			sync_reg <= 5'h00;
		end else if (ce_i) begin
			meta_reg <= {wp_n_i, hold_n_i, mosi_i, sck_i, cs_n_i};
			sync_reg <= meta_reg;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sck_prev_reg <= 1'b0;
			cs_prev_reg <= 1'b0;
		end else if (ce_i) begin
			sck_prev_reg <= sync_reg[1];
			cs_prev_reg <= sync_reg[0];
		end
	end

	// pause changes only while the clock is low; a change seen with the clock high waits for it to fall
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			hold_reg <= 1'b0;
		end else if (ce_i) begin
			if (sync_reg[0]) begin
				hold_reg <= 1'b0; // see [R7]
			end else if (!sync_reg[1]) begin
				hold_reg <= !sync_reg[3]; // see [R18]
			end
		end
	end

	// the two supported modes differ only in idle level, so rising edges sample in both
	assign pin.sck_rise = sync_reg[1] & !sck_prev_reg; // see [R9]
	assign pin.sck_fall = !sync_reg[1] & sck_prev_reg;
	assign pin.cs_fall = !sync_reg[0] & cs_prev_reg;
	assign pin.cs_rise = sync_reg[0] & !cs_prev_reg;
	assign pin.selected = !sync_reg[0];
	assign pin.mosi = sync_reg[2];
	assign pin.hold_active = hold_reg;
	assign pin.wp_n = sync_reg[4];
endmodule // sft_pin_sync

/* File: sft_pkg.sv */
// sft_pkg: constants and types shared by the serial flash target files.
// assumes a 250 MHz system clock and a word-wide AHB-Lite register port.
package sft_pkg;

	localparam int unsigned ADDR_W = 18;
	localparam int unsigned MEM_BYTES = 262144;
	localparam int unsigned PAGE_BYTES = 256;
	localparam int unsigned SECTOR_BYTES = 65536;

	// instruction codes
	localparam logic [7:0] OPC_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] OPC_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] OPC_STATUS_WRITE = 8'h01;
	localparam logic [7:0] OPC_STATUS_READ = 8'h05;
	localparam logic [7:0] OPC_DATA_READ = 8'h03;
	localparam logic [7:0] OPC_PAGE_PROGRAM = 8'h02;
	localparam logic [7:0] OPC_SECTOR_ERASE = 8'hD8;
	localparam logic [7:0] OPC_BULK_ERASE = 8'hC7;

	// frame lengths in bytes
	localparam logic [3:0] LEN_SHORT = 4'h1;
	localparam logic [3:0] LEN_STATUS_WRITE = 4'h2;
	localparam logic [3:0] LEN_SECTOR_ERASE = 4'h4;
	localparam logic [3:0] LEN_PROGRAM_MIN = 4'h5;
	localparam logic [3:0] LEN_SATURATE = 4'hF;

	// status byte layout seen on the serial link
	localparam int unsigned SB_BUSY = 0;
	localparam int unsigned SB_WEL = 1;
	localparam int unsigned SB_BP_LO = 2;
	localparam int unsigned SB_BP_HI = 3;
	localparam int unsigned SB_SRWD = 7;

	// register map (byte addresses)
	localparam logic [7:0] REG_STATUS = 8'h00;
	localparam logic [7:0] REG_CTRL = 8'h04;
	localparam logic [7:0] REG_PEEK_ADDR = 8'h08;
	localparam logic [7:0] REG_PEEK_DATA = 8'h0C;

	// bits of REG_STATUS above the serial status byte
	localparam int unsigned ST_ARMED = 8;
	localparam int unsigned ST_SELECTED = 9;
	localparam int unsigned ST_HOLD = 10;
	localparam int unsigned ST_STANDBY = 11;

	localparam int unsigned CTRL_INHIBIT = 0;
	localparam logic CTRL_INHIBIT_RST = 1'b0;
	localparam logic [1:0] BP_RST = 2'h0;
	localparam logic SRWD_RST = 1'b0;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	// timing
	localparam int unsigned CLK_PERIOD_NS = 4;
	localparam int unsigned STATUS_WRITE_TIME_NS = 400;
	localparam int unsigned STATUS_WRITE_CYCLES = (STATUS_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		OP_IDLE,
		OP_PROGRAM,
		OP_ERASE,
		OP_STATUS
	} sft_op_state_t;

endpackage

/* File: sft_spi_master.sv */
// sft_spi_master: behavioural SPI bus master on the flash target's link pins.
// assumes the bench loads tx_q and calls frame(); link clock period 125 ns.
`timescale 1ns/1ps
module sft_spi_master (
	output logic cs_n_o,
	output logic sck_o,
	output logic mosi_o,
	output logic hold_n_o,
	input wire logic miso_i
);
	logic [7:0] tx_q[$];
	logic [7:0] rx_q[$];
	logic cpol;
	int pause_bit;
	// selected from power-up, so the first frame brings no select fall
	initial begin
		cs_n_o = 1'b0;
		sck_o = 1'b0;
		mosi_o = 1'b0;
		hold_n_o = 1'b1;
		cpol = 1'b0;
		pause_bit = -1;
	end
	task automatic half();
		#62.5;
	endtask
	// clock and data toggle meanwhile, to prove they are ignored
	task automatic pause();
		hold_n_o = 1'b0;
		repeat (3) begin
			half();
			sck_o = 1'b1;
			mosi_o = ~mosi_o;
			half();
			sck_o = 1'b0;
		end
		half();
		hold_n_o = 1'b1;
		half();
	endtask
	task automatic frame(input int nbits);
		logic [7:0] rx;
		rx = 8'h00;
		rx_q.delete();
		sck_o = cpol;
		#31.7;
		cs_n_o = 1'b0;
		half();
		for (int i = 0; i < nbits; i++) begin
			sck_o = 1'b0;
			if (i == pause_bit) begin
				pause();
			end
			mosi_o = tx_q[i / 8][7 - i % 8];
			half();
			sck_o = 1'b1;
			rx = {rx[6:0], miso_i};
			if (i % 8 == 7) begin
				rx_q.push_back(rx);
			end
			half();
		end
		sck_o = cpol;
		half();
		cs_n_o = 1'b1;
		mosi_o = ~mosi_o;
		half();
	endtask
endmodule // sft_spi_master
